/* hdl/ssl_regs.sv */
// spindle speed loop registers behind the 16-bit serial port
`timescale 1ns/1ps
`default_nettype none
`include "ssl_defs.svh"

// What this block does
// - the four-bit delay field sets zero-crossing to commutation delay, nominal 30 degrees
// - delay runs 1.875 to 30 electrical degrees, one 1.875 step per code
// - register 4Eh holds coarse counter bits 4 to 11
// - register 5Eh bits 4 to 7 hold coarse counter bits 0 to 3
// - fine counter is 11 bits: high three in 5Eh, low eight in 6Eh
// - 5Eh bit 3 selects two-phase brake when one, three-phase when zero
// - status bit 0 drops above 160 C, returns only below 130 C
// - while bit 0 is zero both spindle driver sides are high impedance
// - status bit 1 reads zero about 25 C before shutdown
// - status bit 2 reads zero when zero crossings stop, rotor stalled
// - status bit 3 reads one on rapid deceleration or fast zero-cross toggling
// - status bit 4 reads zero while back-EMF detection is blanked
// - status bit 5 reads zero when the spindle period exceeds 16 ms
// - status bits 6 and 7 read zero in align and go phases
// - 8Eh bit 0 selects chopping slew 10 or 20 V per microsecond
// - 8Eh bit 1 selects pump current 25 uA when one, 100 uA when zero
// - sense select routes sense amplifier to zero-cross pin, limit about one third
// - limit bits and sense select pick one of eight sense voltage limits
// - 8Eh bits 6 and 7 force the charge pump low or high
// - enable high then 16 rising clocks; latch after 16th, abort if early drop
// - frame is LSB first: direction bit, seven address bits, then data
module ssl_regs #(
	parameter int unsigned SPEED_LIMIT_CYC = `SSL_SPEED_LIMIT_CYC
) (
	input  wire logic                 i_mclk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_ce,
	input  wire logic                 i_sclk,
	input  wire logic                 i_serial_enable_pin,
	input  wire logic                 i_serial_data_pin,
	output logic                      o_serial_data_pin,
	output logic                      o_serial_data_oe,
	input  wire logic [3:0]           i_commutation_delay_field,
	input  wire logic                 i_temp_above_160,
	input  wire logic                 i_temp_below_130,
	input  wire logic                 i_temp_warn_n,
	input  wire logic                 i_rotor_turning,
	input  wire logic                 i_fault,
	input  wire logic                 i_bemf_unmasked,
	input  wire logic                 i_speed_sample,
	input  wire logic                 i_not_align,
	input  wire logic                 i_not_go,
	input  wire logic                 i_zero_cross,
	input  wire logic                 i_sense_amp,
	output ssl_pkg::ssl_speed_cfg_t   o_speed_cfg,
	output logic [4:0]                o_comm_delay_steps,
	output logic [9:0]                o_sense_limit_mv,
	output logic                      o_driver_hiz,
	output logic                      o_zero_cross_output_pin,
	output ssl_pkg::ssl_status_t      o_status
);

	localparam int unsigned NPIN = 11;
	localparam int unsigned P_HOT = 0;
	localparam int unsigned P_COOL = 1;
	localparam int unsigned P_WARN = 2;
	localparam int unsigned P_TURN = 3;
	localparam int unsigned P_FAULT = 4;
	localparam int unsigned P_UNMASK = 5;
	localparam int unsigned P_SAMPLE = 6;
	localparam int unsigned P_NALIGN = 7;
	localparam int unsigned P_NGO = 8;
	localparam int unsigned P_ZC = 9;
	localparam int unsigned P_SENSE = 10;

	////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers

	logic            rst_q1;
	logic            rst_n;
	logic [NPIN-1:0] pin_q1;
	logic [NPIN-1:0] pin_q2;
	logic            sample_q3;
	logic [NPIN-1:0] pin_raw;

	assign pin_raw = {i_sense_amp, i_zero_cross, i_not_go, i_not_align,
		i_speed_sample, i_bemf_unmasked, i_fault, i_rotor_turning,
		i_temp_warn_n, i_temp_below_130, i_temp_above_160};

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q1    <= '0;
			pin_q2    <= '0;
			sample_q3 <= 1'b0;
		end else if (i_ce) begin
			pin_q1    <= pin_raw;
			pin_q2    <= pin_q1;
			sample_q3 <= pin_q2[P_SAMPLE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link side: shift register on the serial clock

	// the enable pin frames the transfer; an early drop clears the count
	logic                  frame_rst_n;
	logic [4:0]            bit_cnt_q;
	logic [15:0]           sh_q;
	logic [15:0]           sh_d;
	logic [15:0]           word_q;
	logic                  wtog_q;
	logic [7:0]            out_q;
	ssl_pkg::ssl_shift_st_t sh_st_q;
	ssl_pkg::ssl_status_t  stat_s1;
	ssl_pkg::ssl_status_t  stat_s2;

	assign frame_rst_n = rst_n & i_serial_enable_pin;
	assign sh_d = {i_serial_data_pin, sh_q[15:1]};

	always_ff @(posedge i_sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_q <= 5'h00;
			sh_q      <= 16'h0000;
		end else if (bit_cnt_q != `SSL_FRAME_BITS) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
			sh_q      <= sh_d;
		end
	end

	// held word crosses to the main clock by a toggle
	always_ff @(posedge i_sclk or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= 16'h0000;
			wtog_q <= 1'b0;
		end else if (i_serial_enable_pin
				&& bit_cnt_q == `SSL_FRAME_BITS - 5'h01
				&& !sh_d[0]) begin
			word_q <= sh_d;
			wtog_q <= ~wtog_q;
		end
	end

	// status bits are independent levels, so per-bit synchronisers suffice
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_stat_sync
			always_ff @(posedge i_sclk or negedge rst_n) begin
				if (!rst_n) begin
					stat_s1[gi] <= 1'b0;
					stat_s2[gi] <= 1'b0;
				end else begin
					stat_s1[gi] <= o_status[gi];
					stat_s2[gi] <= stat_s1[gi];
				end
			end
		end
	endgenerate

	// read data goes out on falling edges after the header byte
	always_ff @(negedge i_sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			sh_st_q <= ssl_pkg::SSL_SH_IDLE;
			out_q   <= `SSL_RST_BYTE;
		end else begin
			unique case (sh_st_q)
				ssl_pkg::SSL_SH_IDLE: begin
					sh_st_q <= ssl_pkg::SSL_SH_HDR;
				end
				ssl_pkg::SSL_SH_HDR: begin
					if (bit_cnt_q == `SSL_HDR_BITS && sh_q[8]
							&& {sh_q[15:9], 1'b0} == `SSL_OFF_STATUS) begin
						sh_st_q <= ssl_pkg::SSL_SH_DATA;
						out_q   <= stat_s2;
					end
				end
				ssl_pkg::SSL_SH_DATA: begin
					if (bit_cnt_q == `SSL_FRAME_BITS) begin
						sh_st_q <= ssl_pkg::SSL_SH_IDLE;
					end
					out_q <= {1'b0, out_q[7:1]};
				end
				default: begin
					sh_st_q <= ssl_pkg::SSL_SH_IDLE;
				end
			endcase
		end
	end

	assign o_serial_data_oe  = (sh_st_q == ssl_pkg::SSL_SH_DATA);
	assign o_serial_data_pin = out_q[0];

	////////////////////////////////////////////////////////////////////////
	// main clock: write decode

	logic       wtog_q1;
	logic       wtog_q2;
	logic       wtog_q3;
	logic       wr_pulse;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] coarse_hi_q;
	logic [7:0] mixed_q;
	logic [7:0] fine_lo_q;
	logic [7:0] cfg_q;

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			wtog_q1 <= 1'b0;
			wtog_q2 <= 1'b0;
			wtog_q3 <= 1'b0;
		end else if (i_ce) begin
			wtog_q1 <= wtog_q;
			wtog_q2 <= wtog_q1;
			wtog_q3 <= wtog_q2;
		end
	end

	assign wr_pulse = i_ce & (wtog_q2 ^ wtog_q3);
	assign wr_addr  = {word_q[7:1], 1'b0};
	assign wr_data  = word_q[15:8];

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			coarse_hi_q <= `SSL_RST_BYTE;
			mixed_q     <= `SSL_RST_BYTE;
			fine_lo_q   <= `SSL_RST_BYTE;
			cfg_q       <= `SSL_RST_BYTE;
		end else if (wr_pulse) begin
			unique case (wr_addr)
				`SSL_OFF_COARSE_HI: coarse_hi_q <= wr_data;
				`SSL_OFF_MIXED:     mixed_q     <= wr_data;
				`SSL_OFF_FINE_LO:   fine_lo_q   <= wr_data;
				// bit 2 is stored but steers nothing
				`SSL_OFF_CFG:       cfg_q       <= wr_data;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		o_speed_cfg.coarse_count = {coarse_hi_q,
			mixed_q[`SSL_MIX_COARSE_LSB +: 4]};
		o_speed_cfg.fine_count = {mixed_q[`SSL_MIX_FINE_LSB +: 3],
			fine_lo_q};
		o_speed_cfg.two_phase_brake = mixed_q[`SSL_MIX_BRAKE_BIT];
		o_speed_cfg.chop_edge_rate_select = cfg_q[`SSL_CFG_SLEW_BIT];
		o_speed_cfg.pump_current_select = cfg_q[`SSL_CFG_ICP_BIT];
		o_speed_cfg.sense_route_select = cfg_q[`SSL_CFG_SENSE_ROUTE_SELECT_BIT];
		o_speed_cfg.limit_code_high = cfg_q[`SSL_CFG_IL1_BIT];
		o_speed_cfg.limit_code_low = cfg_q[`SSL_CFG_IL0_BIT];
		o_speed_cfg.pump_force_down = cfg_q[`SSL_CFG_CPL_BIT];
		o_speed_cfg.pump_force_up = cfg_q[`SSL_CFG_CPH_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// main clock: derived settings

	logic [2:0] lim_sel;

	assign lim_sel = {cfg_q[`SSL_CFG_SENSE_ROUTE_SELECT_BIT], cfg_q[`SSL_CFG_IL1_BIT],
		cfg_q[`SSL_CFG_IL0_BIT]};

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_sense_limit_mv   <= `SSL_LIM_N0_MV;
			o_comm_delay_steps <= 5'h01;
		end else if (i_ce) begin
			unique case (lim_sel)
				3'h0: o_sense_limit_mv <= `SSL_LIM_N0_MV;
				3'h1: o_sense_limit_mv <= `SSL_LIM_N1_MV;
				3'h2: o_sense_limit_mv <= `SSL_LIM_N2_MV;
				3'h3: o_sense_limit_mv <= `SSL_LIM_N3_MV;
				3'h4: o_sense_limit_mv <= `SSL_LIM_S0_MV;
				3'h5: o_sense_limit_mv <= `SSL_LIM_S1_MV;
				3'h6: o_sense_limit_mv <= `SSL_LIM_S2_MV;
				3'h7: o_sense_limit_mv <= `SSL_LIM_S3_MV;
			endcase
			// one 1.875 degree step per code, code 15 gives 30 degrees
			o_comm_delay_steps <= {1'b0, i_commutation_delay_field}
				+ 5'h01;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_zero_cross_output_pin <= 1'b0;
		end else if (i_ce) begin
			o_zero_cross_output_pin <= cfg_q[`SSL_CFG_SENSE_ROUTE_SELECT_BIT]
				? pin_q2[P_SENSE] : pin_q2[P_ZC];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// main clock: status flags

	logic        thermal_ok_q;
	logic [31:0] period_q;
	logic        speed_ok_q;

	// hysteresis between the two comparators
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			thermal_ok_q <= 1'b1;
		end else if (i_ce) begin
			if (pin_q2[P_HOT]) begin
				thermal_ok_q <= 1'b0;
			end else if (pin_q2[P_COOL]) begin
				thermal_ok_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_driver_hiz <= 1'b1;
		end else if (i_ce) begin
			o_driver_hiz <= ~thermal_ok_q;
		end
	end

	// after reset no sample has been seen, so speed reads as in error
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			period_q   <= 32'h0000_0000;
			speed_ok_q <= 1'b0;
		end else if (i_ce) begin
			if (pin_q2[P_SAMPLE] && !sample_q3) begin
				period_q   <= 32'h0000_0000;
				speed_ok_q <= 1'b1;
			end else if (period_q >= SPEED_LIMIT_CYC) begin
				speed_ok_q <= 1'b0;
			end else begin
				period_q <= period_q + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_status <= '0;
		end else if (i_ce) begin
			o_status.thermal_ok          <= thermal_ok_q;
			o_status.overheat_early_flag <= pin_q2[P_WARN];
			o_status.rotor_stalled_flag  <= pin_q2[P_TURN];
			o_status.fault               <= pin_q2[P_FAULT];
			o_status.bemf_unmasked       <= pin_q2[P_UNMASK];
			o_status.speed_ok            <= speed_ok_q;
			o_status.not_align           <= pin_q2[P_NALIGN];
			o_status.not_go              <= pin_q2[P_NGO];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!rst_n);

	AST_HOT_CLEARS: assert property (i_ce && pin_q2[P_HOT] |=> !thermal_ok_q)
		else $error("overtemperature did not clear thermal flag");
	AST_HYST_HOLD: assert property (i_ce && !thermal_ok_q && !pin_q2[P_COOL]
		|=> !thermal_ok_q)
		else $error("thermal flag returned before cool-down");
	AST_HIZ: assert property (i_ce && !thermal_ok_q |=> o_driver_hiz)
		else $error("drivers not tristated while hot");
	AST_COARSE: assert property (o_speed_cfg.coarse_count[3:0]
		== mixed_q[7:4] && o_speed_cfg.coarse_count[11:4] == coarse_hi_q)
		else $error("coarse count assembled wrongly");
	AST_WRITE_CFG: assert property (wr_pulse && wr_addr == `SSL_OFF_CFG
		|=> cfg_q == $past(wr_data))
		else $error("configuration write lost");
	AST_LIMIT: assert property (i_ce && lim_sel == 3'h7
		|=> o_sense_limit_mv == `SSL_LIM_S3_MV)
		else $error("sense limit wrong");
	AST_DELAY: assert property (i_ce && i_commutation_delay_field == 4'hf
		|=> o_comm_delay_steps == 5'h10)
		else $error("full delay code not 30 degrees");
	AST_SPEED: assert property (i_ce && period_q >= SPEED_LIMIT_CYC
		&& !(pin_q2[P_SAMPLE] && !sample_q3) |=> !speed_ok_q)
		else $error("speed timeout not flagged");
	AST_ROUTE: assert property (i_ce && cfg_q[3] && $stable(cfg_q)
		|=> o_zero_cross_output_pin == $past(pin_q2[P_SENSE]))
		else $error("sense amplifier not routed");
	AST_FRAME_CAP: assert property (@(posedge i_sclk) disable iff (!frame_rst_n)
		bit_cnt_q <= `SSL_FRAME_BITS)
		else $error("more than sixteen bits shifted");

	COV_WRITE_CFG: cover property (wr_pulse && wr_addr == `SSL_OFF_CFG);
	COV_WRITE_MIX: cover property (wr_pulse && wr_addr == `SSL_OFF_MIXED);
	COV_HOT_COOL: cover property (!thermal_ok_q ##[1:50] thermal_ok_q);
	COV_READ: cover property (@(posedge i_sclk) disable iff (!rst_n)
		sh_st_q == ssl_pkg::SSL_SH_DATA);

endmodule : ssl_regs

`default_nettype wire

/* inc/ssl_defs.svh */
// offsets, field positions, reset values and timing counts for the speed loop
`ifndef SSL_DEFS_SVH
`define SSL_DEFS_SVH

`define SSL_OFF_COARSE_HI   8'h4e
`define SSL_OFF_MIXED       8'h5e
`define SSL_OFF_FINE_LO     8'h6e
`define SSL_OFF_STATUS      8'h7e
`define SSL_OFF_CFG         8'h8e

`define SSL_MIX_FINE_LSB    0
`define SSL_MIX_BRAKE_BIT   3
`define SSL_MIX_COARSE_LSB  4
`define SSL_CFG_SLEW_BIT    0
`define SSL_CFG_ICP_BIT     1
`define SSL_CFG_SENSE_ROUTE_SELECT_BIT    3
`define SSL_CFG_IL1_BIT     4
`define SSL_CFG_IL0_BIT     5
`define SSL_CFG_CPL_BIT     6
`define SSL_CFG_CPH_BIT     7

`define SSL_RST_BYTE        8'h00
`define SSL_FRAME_BITS      5'h10
`define SSL_HDR_BITS        5'h08

`define SSL_CLK_PERIOD_PS   5000
`define SSL_SPEED_LIMIT_MS  16
// reckoned in ns so the product stays inside 32 bits
`define SSL_SPEED_LIMIT_CYC ((`SSL_SPEED_LIMIT_MS * 1000000) / (`SSL_CLK_PERIOD_PS / 1000))

`define SSL_LIM_N0_MV       10'h1c2
`define SSL_LIM_N1_MV       10'h1f4
`define SSL_LIM_N2_MV       10'h226
`define SSL_LIM_N3_MV       10'h2ee
`define SSL_LIM_S0_MV       10'h096
`define SSL_LIM_S1_MV       10'h0c8
`define SSL_LIM_S2_MV       10'h0fa
`define SSL_LIM_S3_MV       10'h12c

`endif

/* inc/ssl_pkg.sv */
// types shared by the spindle speed loop register bank
package ssl_pkg;

	// status byte, bit 7 first
	typedef struct packed {
		logic not_go;
		logic not_align;
		logic speed_ok;
		logic bemf_unmasked;
		logic fault;
		logic rotor_stalled_flag;
		logic overheat_early_flag;
		logic thermal_ok;
	} ssl_status_t;

	typedef struct packed {
		logic [11:0] coarse_count;
		logic [10:0] fine_count;
		logic        two_phase_brake;
		logic        chop_edge_rate_select;
		logic        pump_current_select;
		logic        sense_route_select;
		logic        limit_code_high;
		logic        limit_code_low;
		logic        pump_force_down;
		logic        pump_force_up;
	} ssl_speed_cfg_t;

	typedef enum logic [2:0] {
		SSL_SH_IDLE = 3'b001,
		SSL_SH_HDR  = 3'b010,
		SSL_SH_DATA = 3'b100
	} ssl_shift_st_t;

endpackage : ssl_pkg

/* tb/ssl_host_model.sv */
// drive processor model on the serial register port
`timescale 1ns/1ps
`default_nettype none
module ssl_host_model (
	output logic      o_sclk,
	output logic      o_enable,
	output logic      o_data,
	input  wire logic i_pin
);
	initial begin
		o_sclk = 1'b0;
		o_enable = 1'b0;
		o_data = 1'b0;
	end
	//////////////////////////////////////////////////////////////////////
	// nclk below 16 aborts, above 16 sends extra ignored clocks
	// sclk only runs inside a frame
	task automatic xfer(input logic [15:0] word, input int nclk,
		output logic [7:0] rd);
		rd = 8'h00;
		if (word[7:0] == 8'h8e)
			word[10] = 1'b0;
		o_enable = 1'b1;
		#35;
		for (int i = 0; i < nclk; i++) begin
			// released during read data: toggle so stale bits never match
			o_data = (word[0] && i >= 8) ? ~o_data : word[i % 16];
			#4.5 o_sclk = 1'b1;
			if (i >= 8 && i < 16)
				rd[i - 8] = i_pin;
			#7.5 o_sclk = 1'b0;
			#3;
		end
		#20 o_enable = 1'b0;
		o_data = ~o_data;
		#50;
	endtask : xfer
endmodule : ssl_host_model
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the speed loop register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int LIM = 50;
	localparam logic [9:0] LIMS [8] = '{10'h1c2, 10'h1f4, 10'h226, 10'h2ee,
		10'h096, 10'h0c8, 10'h0fa, 10'h12c};
	logic i_mclk, i_rst_n, i_ce, sclk, sen, h_data, serial_data_pin, dev_o, dev_oe;
	logic [3:0] dly;
	logic t160, t130, warn_n, turning, fault, unmask, spd, nalign, ngo;
	logic zc, sa, hiz, zpin, spd_run;
	ssl_pkg::ssl_speed_cfg_t cfg;
	ssl_pkg::ssl_status_t    st;
	logic [4:0]  steps;
	logic [9:0]  lim_mv;
	logic [7:0]  r4e, r5e, r6e, r8e, rb, sx;
	logic [31:0] exp_q[$];
	logic [31:0] obs, e_m, keep;
	string       nm;
	event        got;
	int          err_count, num_checks;

	assign serial_data_pin = dev_oe ? dev_o : h_data;

	ssl_regs #(.SPEED_LIMIT_CYC(LIM)) u_ssl_regs (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_sclk(sclk),
		.i_serial_enable_pin(sen), .i_serial_data_pin(serial_data_pin),
		.o_serial_data_pin(dev_o), .o_serial_data_oe(dev_oe),
		.i_commutation_delay_field(dly), .i_temp_above_160(t160),
		.i_temp_below_130(t130), .i_temp_warn_n(warn_n),
		.i_rotor_turning(turning), .i_fault(fault),
		.i_bemf_unmasked(unmask), .i_speed_sample(spd),
		.i_not_align(nalign), .i_not_go(ngo), .i_zero_cross(zc),
		.i_sense_amp(sa), .o_speed_cfg(cfg), .o_comm_delay_steps(steps),
		.o_sense_limit_mv(lim_mv), .o_driver_hiz(hiz),
		.o_zero_cross_output_pin(zpin), .o_status(st));

	ssl_host_model u_ssl_host_model (
		.o_sclk(sclk), .o_enable(sen), .o_data(h_data), .i_pin(serial_data_pin));

	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	always @(posedge i_mclk)
		spd <= spd_run ? ~spd : 1'b0;
	//////////////////////////////////////////////////////////////////////
	always @(got) begin
		e_m = exp_q.pop_front();
		num_checks++;
		if (obs !== e_m) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e_m, obs);
		end
	end

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] o);
		exp_q.push_back(e);
		nm = n;
		obs = o;
		->got;
		#1;
	endtask : chk

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_ssl_host_model.xfer({d, a}, 16, rb);
		repeat (8) @(posedge i_mclk);
	endtask : wr

	function automatic logic [31:0] cfg_exp();
		return {1'b0, r4e, r5e[7:4], r5e[2:0], r6e, r5e[3], r8e[0], r8e[1],
			r8e[3], r8e[4], r8e[5], r8e[6], r8e[7]};
	endfunction : cfg_exp

	task automatic wait_n(input int n);
		repeat (n) @(posedge i_mclk);
	endtask : wait_n
	//////////////////////////////////////////////////////////////////////
	initial begin
		{i_ce, t130, warn_n, turning, unmask, nalign, ngo} = 7'h7f;
		{t160, fault, zc, sa, spd_run} = 5'h00;
		dly = 4'h0;
		i_rst_n = 1'b0;
		void'($urandom(70));
		wait_n(4);
		i_rst_n <= 1'b1;
		wait_n(6);
		chk("cfg", 32'h0, cfg);
		chk("limit", 32'h1c2, lim_mv);
		chk("speed", 32'h0, st.speed_ok);
		chk("hiz", 32'h0, hiz);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			r4e = 8'($urandom);
			r5e = 8'($urandom);
			r6e = 8'($urandom);
			r8e = (8'($urandom) & 8'hc3) | {2'h0, k[0], k[1], k[2], 3'h0};
			wr(8'h4e, r4e);
			wr(8'h5e, r5e);
			wr(8'h6e, r6e);
			wr(8'h8e, r8e);
			@(posedge i_mclk);
			{zc, sa} <= 2'($urandom);
			wait_n(6);
			chk("cfg", cfg_exp(), cfg);
			chk("limit", LIMS[k], lim_mv);
			chk("zpin", r8e[3] ? sa : zc, zpin);
		end
		$display("test config done");
		for (int c = 0; c < 16; c++) begin
			@(posedge i_mclk);
			dly <= 4'(c);
			wait_n(4);
			chk("steps", c + 1, steps);
		end
		$display("test delay done");
		keep = cfg_exp();
		u_ssl_host_model.xfer(16'hff4e, 15, rb);
		wr(8'h9e, 8'hff);
		chk("cfg abort", keep, cfg);
		r6e = 8'($urandom);
		u_ssl_host_model.xfer({r6e, 8'h6e}, 20, rb);
		wait_n(8);
		chk("cfg long", cfg_exp(), cfg);
		$display("test framing done");
		spd_run <= 1'b1;
		wait_n(20);
		chk("speed", 32'h1, st.speed_ok);
		spd_run <= 1'b0;
		wait_n(LIM - 10);
		chk("speed", 32'h1, st.speed_ok);
		wait_n(20);
		chk("speed", 32'h0, st.speed_ok);
		spd_run <= 1'b1;
		$display("test speed done");
		for (int k = 0; k < 4; k++) begin
			@(posedge i_mclk);
			{warn_n, turning, fault, unmask, nalign, ngo} <= 6'($urandom);
			wait_n(8);
			sx = {ngo, nalign, 1'b1, unmask, fault, turning, warn_n, 1'b1};
			chk("status", sx, st);
			u_ssl_host_model.xfer(16'h007f, 16, rb);
			chk("read", sx, rb);
			u_ssl_host_model.xfer(16'h007f, 16, rb);
			chk("reread", sx, rb);
		end
		$display("test status done");
		@(posedge i_mclk);
		t160 <= 1'b1;
		wait_n(8);
		chk("thermal", 32'h0, st.thermal_ok);
		chk("hiz", 32'h1, hiz);
		{t160, t130} <= 2'b00;
		wait_n(8);
		chk("thermal", 32'h0, st.thermal_ok);
		u_ssl_host_model.xfer(16'h007f, 16, rb);
		chk("read hot", 32'h0, rb[0]);
		@(posedge i_mclk);
		t130 <= 1'b1;
		wait_n(8);
		chk("thermal", 32'h1, st.thermal_ok);
		chk("hiz", 32'h0, hiz);
		$display("test thermal done");
		conclude();
	end

	initial begin
		#200000;
		err_count++;
		conclude();
	end
endmodule : tb
`default_nettype wire
